// file: design/led_fc_pkg.sv
// Constants, field layout and helpers for the LED driver control write path
package led_fc_pkg;

    // Shift register, control register and counter widths
    localparam int SHIFT_W = 48;
    localparam int PRIMARY_W = 44;
    localparam int SECONDARY_W = 17;
    localparam int CNT_W = 8;
    localparam int FILL_W = 6;

    // Target select field in the top of the shift register
    localparam int SEL_HI = 47;
    localparam int SEL_LO = 44;
    localparam logic [3:0] SEL_PRIMARY = 4'h9;
    localparam logic [3:0] SEL_SECONDARY = 4'h6;

    // Rising-edge counts that identify the commands
    localparam logic [CNT_W-1:0] EDGES_DATA_WRITE = 8'h05;
    localparam logic [CNT_W-1:0] EDGES_UNLOCK = 8'h0f;
    localparam logic [CNT_W-1:0] EDGES_GS_DEFAULT = 8'h01;

    // Primary register field positions
    localparam int THR_LO = 0;
    localparam int THR_HI = 1;
    localparam int HOLD_LO = 2;
    localparam int HOLD_HI = 3;
    localparam int GHOST_BIT = 4;
    localparam int PRECH_OFF_BIT = 8;
    localparam int PRECH_ALT_BIT = 9;
    localparam int CENTER_OFF_BIT = 13;
    localparam int BLUE_LO = 14;
    localparam int BLUE_HI = 22;
    localparam int GREEN_LO = 23;
    localparam int GREEN_HI = 31;
    localparam int RED_LO = 32;
    localparam int RED_HI = 40;
    localparam int BRIGHT_LO = 41;
    localparam int BRIGHT_HI = 43;

    // Secondary register field used here
    localparam int SEC_PRECH_SEL_BIT = 7;

    // Reset values, and the full count of the fill counter
    localparam logic [1:0] THR_RST = 2'h1;
    localparam logic [1:0] HOLD_RST = 2'h1;
    localparam logic GHOST_RST = 1'h1;
    localparam logic [8:0] RSV_LOW_RST = 9'h000;
    localparam logic [8:0] LEVEL_RST = 9'h100;
    localparam logic [2:0] BRIGHT_RST = 3'h4;
    localparam logic [PRIMARY_W-1:0] PRIMARY_RST = {BRIGHT_RST, LEVEL_RST, LEVEL_RST, LEVEL_RST,
                                                   RSV_LOW_RST, GHOST_RST, HOLD_RST, THR_RST};
    localparam logic [SECONDARY_W-1:0] SECONDARY_RST = 17'h0_0000;
    localparam logic [FILL_W-1:0] FILL_FULL = 6'h30;

    // Core-side command tracking
    typedef enum logic {ST_IDLE, ST_STROBE} strobe_state_t;

    // Binary to gray for the edge counter crossing
    function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray back to binary on the core side
    function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = g;
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// file: design/link_shift_capture.sv
// Shift-clock side: common shift register, strobe edge counter, serial output
`timescale 1ns/1ns
`default_nettype none
module link_shift_capture (
    input wire logic shiftClk,
    input wire logic reset,
    input wire logic serialDataIn,
    input wire logic latchStrobe,
    output logic [led_fc_pkg::SHIFT_W-1:0] shiftSnap_r,
    output logic [led_fc_pkg::CNT_W-1:0] edgeGray_r,
    output logic serialDataOut_r
);
    import led_fc_pkg::*;

    logic resetMeta_r;
    logic resetSync_r;
    logic [SHIFT_W-1:0] shift_r;
    logic [SHIFT_W-1:0] shift_nxt;
    logic [SHIFT_W-1:0] shiftSnap_nxt;
    logic [CNT_W-1:0] edgeBin_r;
    logic [CNT_W-1:0] edgeBin_nxt;
    logic [CNT_W-1:0] edgeGray_nxt;
    logic serialDataOut_nxt;
    logic [FILL_W-1:0] fill_r;

    // Core reset brought onto the shift clock
    always_ff @(posedge shiftClk) begin
        resetMeta_r <= reset;
        resetSync_r <= resetMeta_r;
    end

    // Shift on every edge; snapshot and count only while the strobe is high
    always_comb begin
        shift_nxt = {shift_r[SHIFT_W-2:0], serialDataIn};
        shiftSnap_nxt = shiftSnap_r;
        edgeBin_nxt = edgeBin_r;
        if (latchStrobe) begin
            shiftSnap_nxt = shift_nxt;
            edgeBin_nxt = edgeBin_r + 1'b1;
        end
        edgeGray_nxt = bin2gray(edgeBin_nxt);
        serialDataOut_nxt = shift_nxt[SHIFT_W-1];
    end

    // Snapshot stays put while the strobe is low, so the core can read it slowly
    always_ff @(posedge shiftClk) begin
        if (resetSync_r) begin
            shift_r <= '0;
            shiftSnap_r <= '0;
            edgeBin_r <= '0;
            edgeGray_r <= '0;
            serialDataOut_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            shiftSnap_r <= shiftSnap_nxt;
            edgeBin_r <= edgeBin_nxt;
            edgeGray_r <= edgeGray_nxt;
            serialDataOut_r <= serialDataOut_nxt;
        end
    end

    // Edges since reset, for the delay check below
    always_ff @(posedge shiftClk) begin
        if (resetSync_r) begin
            fill_r <= '0;
        end else if (fill_r != FILL_FULL) begin
            fill_r <= fill_r + 1'b1;
        end
    end

    shiftDelay_a: assert property (@(posedge shiftClk) disable iff (resetSync_r)
        (fill_r == FILL_FULL) |-> serialDataOut_r == $past(serialDataIn, 48))
        else $error("serial output is not the input delayed by the shift length");

endmodule // link_shift_capture
`default_nettype wire

// file: design/led_driver_fc_write_path.sv
// Serial command path: strobe decode, write unlock and function control registers
//
// Overview of operation
// - Shift serial data into 48-bit register
// - Latch shift data by decoded command target
// - Command is count of edges under strobe
// - Data write is exactly five edges
// - Select 1001b loads lower 44 bits primary
// - Select 0110b loads lower 17 bits secondary
// - Fifteen edges unlock the next command if it is a data write
// - Data write without prior unlock is ignored
// - Bits 1:0 open detect threshold, reset 01
// - Bits 3:2 output hold select, reset 01
// - Bit 4 ghost cancel enable, reset 1
// - Bit 8 low enables precharge, reset 0
// - Bit 9 alt precharge when secondary bit7
// - Bit 13 low enables center uniformity
// - Three 9-bit colour levels, reset 100h
// - Bits 43:41 global brightness, reset 100b
// - Colour level change applies at once
`timescale 1ns/1ns
`default_nettype none
module led_driver_fc_write_path #(
    parameter logic [led_fc_pkg::CNT_W-1:0] GS_LATCH_EDGES = led_fc_pkg::EDGES_GS_DEFAULT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic shiftClk,
    input wire logic serialDataIn,
    input wire logic latchStrobe,
    output logic serialDataOut_r,
    output logic [led_fc_pkg::PRIMARY_W-1:0] functionControlPrimary_r,
    output logic [led_fc_pkg::SECONDARY_W-1:0] functionControlSecondary_r,
    output logic controlWriteUnlock_r,
    output logic dataWriteRejected_r,
    output logic grayscaleLatch_r,
    output logic [led_fc_pkg::SHIFT_W-1:0] grayscaleData_r,
    output logic [led_fc_pkg::CNT_W-1:0] lastEdgeCount_r,
    output logic [1:0] openDetectThreshold_r,
    output logic [1:0] outputHoldSelect_r,
    output logic ghostCancelEnable_r,
    output logic prechargeOn_r,
    output logic prechargeAltMode_r,
    output logic centerUniformityOn_r,
    output logic [8:0] blueLevel_r,
    output logic [8:0] greenLevel_r,
    output logic [8:0] redLevel_r,
    output logic [2:0] globalBrightness_r
);
    import led_fc_pkg::*;

    logic [SHIFT_W-1:0] linkSnap;
    logic [CNT_W-1:0] linkGray;
    logic latchMeta_r;
    logic latchSync_r;
    logic [CNT_W-1:0] grayMeta_r;
    logic [CNT_W-1:0] graySync_r;
    logic [SHIFT_W-1:0] snapMeta_r;
    logic [SHIFT_W-1:0] snapSync_r;
    logic [CNT_W-1:0] countNow;
    logic [CNT_W-1:0] countDly_r;
    logic [CNT_W-1:0] base_r;
    logic [CNT_W-1:0] base_nxt;
    logic [CNT_W-1:0] edgeCount;
    logic [3:0] targetSel;
    logic decodeNow;
    logic isDataWrite;
    logic isUnlock;
    logic isGsLatch;
    strobe_state_t state_r;
    strobe_state_t state_nxt;
    logic [PRIMARY_W-1:0] primary_nxt;
    logic [SECONDARY_W-1:0] secondary_nxt;
    logic unlock_nxt;
    logic rejected_nxt;
    logic gsLatch_nxt;
    logic [SHIFT_W-1:0] gsData_nxt;
    logic [CNT_W-1:0] lastCount_nxt;

    // Shift-clock domain logic
    link_shift_capture u_link (
        .shiftClk(shiftClk),
        .reset(reset),
        .serialDataIn(serialDataIn),
        .latchStrobe(latchStrobe),
        .shiftSnap_r(linkSnap),
        .edgeGray_r(linkGray),
        .serialDataOut_r(serialDataOut_r)
    );

    // Two-stage synchronisers; snapshot is quiet whenever the strobe is low
    always_ff @(posedge core_clk) begin
        latchMeta_r <= latchStrobe;
        latchSync_r <= latchMeta_r;
        grayMeta_r <= linkGray;
        graySync_r <= grayMeta_r;
        snapMeta_r <= linkSnap;
        snapSync_r <= snapMeta_r;
    end

    // Edges seen under the current strobe pulse
    always_comb begin
        countNow = gray2bin(graySync_r);
        edgeCount = countNow - base_r;
        targetSel = snapSync_r[SEL_HI:SEL_LO];
        decodeNow = (state_r == ST_STROBE) && !latchSync_r;
        isDataWrite = decodeNow && (edgeCount == EDGES_DATA_WRITE);
        isUnlock = decodeNow && (edgeCount == EDGES_UNLOCK);
        isGsLatch = decodeNow && (edgeCount == GS_LATCH_EDGES);
    end

    // Strobe tracking and command decode
    always_comb begin
        state_nxt = state_r;
        base_nxt = base_r;
        primary_nxt = functionControlPrimary_r;
        secondary_nxt = functionControlSecondary_r;
        unlock_nxt = controlWriteUnlock_r;
        rejected_nxt = 1'b0;
        gsLatch_nxt = 1'b0;
        gsData_nxt = grayscaleData_r;
        lastCount_nxt = lastEdgeCount_r;
        unique case (state_r)
            ST_IDLE: begin
                // Delayed copy as base, so an edge seen alongside the rise still counts
                base_nxt = countDly_r;
                if (latchSync_r) begin
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (!latchSync_r) begin
                    state_nxt = ST_IDLE;
                    lastCount_nxt = edgeCount;
                    // Any command other than the unlock consumes the unlock
                    unlock_nxt = 1'b0;
                    if (isUnlock) begin
                        unlock_nxt = 1'b1;
                    end else if (isDataWrite) begin
                        if (!controlWriteUnlock_r) begin
                            rejected_nxt = 1'b1;
                        end else if (targetSel == SEL_PRIMARY) begin
                            primary_nxt = snapSync_r[PRIMARY_W-1:0];
                        end else if (targetSel == SEL_SECONDARY) begin
                            secondary_nxt = snapSync_r[SECONDARY_W-1:0];
                        end
                    end else if (isGsLatch) begin
                        gsLatch_nxt = 1'b1;
                        gsData_nxt = snapSync_r;
                    end
                end
            end
        endcase
    end

    // Command state registers; reserved bits are stored as written
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            countDly_r <= '0;
            base_r <= '0;
            functionControlPrimary_r <= PRIMARY_RST;
            functionControlSecondary_r <= SECONDARY_RST;
            controlWriteUnlock_r <= 1'b0;
            dataWriteRejected_r <= 1'b0;
            grayscaleLatch_r <= 1'b0;
            grayscaleData_r <= '0;
            lastEdgeCount_r <= '0;
        end else begin
            state_r <= state_nxt;
            countDly_r <= countNow;
            base_r <= base_nxt;
            functionControlPrimary_r <= primary_nxt;
            functionControlSecondary_r <= secondary_nxt;
            controlWriteUnlock_r <= unlock_nxt;
            dataWriteRejected_r <= rejected_nxt;
            grayscaleLatch_r <= gsLatch_nxt;
            grayscaleData_r <= gsData_nxt;
            lastEdgeCount_r <= lastCount_nxt;
        end
    end

    // Field outputs load from the next value, so they move with the register itself
    always_ff @(posedge core_clk) begin
        if (reset) begin
            openDetectThreshold_r <= PRIMARY_RST[THR_HI:THR_LO];
            outputHoldSelect_r <= PRIMARY_RST[HOLD_HI:HOLD_LO];
            ghostCancelEnable_r <= PRIMARY_RST[GHOST_BIT];
            prechargeOn_r <= !PRIMARY_RST[PRECH_OFF_BIT];
            prechargeAltMode_r <= 1'b0;
            centerUniformityOn_r <= !PRIMARY_RST[CENTER_OFF_BIT];
            blueLevel_r <= PRIMARY_RST[BLUE_HI:BLUE_LO];
            greenLevel_r <= PRIMARY_RST[GREEN_HI:GREEN_LO];
            redLevel_r <= PRIMARY_RST[RED_HI:RED_LO];
            globalBrightness_r <= PRIMARY_RST[BRIGHT_HI:BRIGHT_LO];
        end else begin
            openDetectThreshold_r <= primary_nxt[THR_HI:THR_LO];
            outputHoldSelect_r <= primary_nxt[HOLD_HI:HOLD_LO];
            ghostCancelEnable_r <= primary_nxt[GHOST_BIT];
            prechargeOn_r <= !primary_nxt[PRECH_OFF_BIT];
            prechargeAltMode_r <= primary_nxt[PRECH_ALT_BIT] && secondary_nxt[SEC_PRECH_SEL_BIT];
            centerUniformityOn_r <= !primary_nxt[CENTER_OFF_BIT];
            blueLevel_r <= primary_nxt[BLUE_HI:BLUE_LO];
            greenLevel_r <= primary_nxt[GREEN_HI:GREEN_LO];
            redLevel_r <= primary_nxt[RED_HI:RED_LO];
            globalBrightness_r <= primary_nxt[BRIGHT_HI:BRIGHT_LO];
        end
    end

    // Checks on the core clock
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    unlockSet_a: assert property (isUnlock |=> controlWriteUnlock_r)
        else $error("unlock command did not arm the data write");

    primaryLoad_a: assert property (
        (isDataWrite && controlWriteUnlock_r && targetSel == SEL_PRIMARY)
        |=> functionControlPrimary_r == $past(snapSync_r[PRIMARY_W-1:0]))
        else $error("primary register not loaded from shift data");

    secondaryLoad_a: assert property (
        (isDataWrite && controlWriteUnlock_r && targetSel == SEL_SECONDARY)
        |=> functionControlSecondary_r == $past(snapSync_r[SECONDARY_W-1:0]))
        else $error("secondary register not loaded from shift data");

    lockedIgnore_a: assert property (
        (isDataWrite && !controlWriteUnlock_r)
        |=> $stable(functionControlPrimary_r) && $stable(functionControlSecondary_r) && dataWriteRejected_r)
        else $error("data write without unlock was not ignored");

    unlockUsed_a: assert property (isDataWrite |=> !controlWriteUnlock_r ##1 !dataWriteRejected_r)
        else $error("unlock survived a data write");

    writeOnlyByCmd_a: assert property (
        !$stable(functionControlPrimary_r) |-> $past(isDataWrite) && $past(edgeCount) == EDGES_DATA_WRITE)
        else $error("primary register changed without a five-edge write");

    resetDefault_a: assert property (
        $past(reset) |-> functionControlPrimary_r == PRIMARY_RST && globalBrightness_r == BRIGHT_RST
        && redLevel_r == LEVEL_RST && openDetectThreshold_r == THR_RST && ghostCancelEnable_r)
        else $error("primary register default wrong after reset");

    prechargeAlt_a: assert property (
        prechargeAltMode_r == (functionControlPrimary_r[PRECH_ALT_BIT]
        && functionControlSecondary_r[SEC_PRECH_SEL_BIT]))
        else $error("alternate precharge not gated by secondary select");

    activeLow_a: assert property (
        prechargeOn_r == !functionControlPrimary_r[PRECH_OFF_BIT]
        && centerUniformityOn_r == !functionControlPrimary_r[CENTER_OFF_BIT])
        else $error("active-low enable bit decoded wrongly");

    levelTrack_a: assert property (
        blueLevel_r == functionControlPrimary_r[BLUE_HI:BLUE_LO]
        && greenLevel_r == functionControlPrimary_r[GREEN_HI:GREEN_LO])
        else $error("colour level output lags the register");

    decodeAtFall_a: assert property (
        (state_r == ST_STROBE && latchSync_r) |=> !grayscaleLatch_r && !dataWriteRejected_r)
        else $error("command decoded while strobe still high");

    gsPulse_a: assert property (grayscaleLatch_r |=> !grayscaleLatch_r)
        else $error("grayscale latch pulse longer than one cycle");

    rejectPulse_a: assert property (dataWriteRejected_r |=> !dataWriteRejected_r)
        else $error("rejected pulse longer than one cycle");

    unlockHold_a: assert property ((controlWriteUnlock_r && !decodeNow) |=> controlWriteUnlock_r)
        else $error("unlock dropped without a decoded command");

    secondaryWrite_a: assert property (
        !$stable(functionControlSecondary_r)
        |-> $past(isDataWrite && controlWriteUnlock_r && targetSel == SEL_SECONDARY))
        else $error("secondary register changed without an unlocked write");

    badSelect_a: assert property (
        (isDataWrite && targetSel != SEL_PRIMARY && targetSel != SEL_SECONDARY)
        |=> $stable(functionControlPrimary_r) && $stable(functionControlSecondary_r))
        else $error("write with unknown select changed a register");

    lastCount_a: assert property (decodeNow |=> lastEdgeCount_r == $past(edgeCount))
        else $error("edge count of the decoded pulse not kept");

    // Guarded against a latch count that collides with the control commands
    gsCapture_a: assert property (
        (isGsLatch && !isUnlock && !isDataWrite)
        |=> grayscaleLatch_r && grayscaleData_r == $past(snapSync_r))
        else $error("grayscale latch did not take the shift snapshot");

    fieldTrack_a: assert property (
        openDetectThreshold_r == functionControlPrimary_r[THR_HI:THR_LO]
        && outputHoldSelect_r == functionControlPrimary_r[HOLD_HI:HOLD_LO]
        && ghostCancelEnable_r == functionControlPrimary_r[GHOST_BIT]
        && globalBrightness_r == functionControlPrimary_r[BRIGHT_HI:BRIGHT_LO])
        else $error("control field output does not match the register");

    unlockCover_c: cover property (isUnlock);
    primaryCover_c: cover property (isDataWrite && controlWriteUnlock_r && targetSel == SEL_PRIMARY);
    secondaryCover_c: cover property (isDataWrite && controlWriteUnlock_r && targetSel == SEL_SECONDARY);
    rejectCover_c: cover property (dataWriteRejected_r);
    gsCover_c: cover property (grayscaleLatch_r);

endmodule // led_driver_fc_write_path
`default_nettype wire

// file: tb/fc_controller_model.sv
// Display controller model: drives shift clock, serial data and latch strobe
`timescale 1ns/1ns
`default_nettype none
module fc_controller_model (
    output logic shiftClk,
    output logic serialDataIn,
    output logic latchStrobe
);
    // Clock parked low and strobe low between frames
    initial begin
        shiftClk = 1'b0;
        serialDataIn = 1'b0;
        latchStrobe = 1'b0;
    end

    // One 12 ns shift period; data moves 1 ns after the falling edge
    task automatic tick();
        #5 shiftClk = 1'b1;
        #6 shiftClk = 1'b0;
        #1;
    endtask

    // Free-running clocks with strobe low, needed while the link side resets
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            serialDataIn = ~serialDataIn;
            tick();
        end
    endtask

    // Whole 48-bit word MSB first; the strobe spans the last nEdges edges
    task automatic send_frame(input logic [47:0] word, input int nEdges);
        for (int i = 47; i >= 0; i--) begin
            serialDataIn = word[i];
            if (i == nEdges - 1) begin
                latchStrobe = 1'b1;
            end
            tick();
        end
        // Short pulses are stretched with the clock stopped, so the core sees them
        if (nEdges > 0) begin
            #40;
        end
        latchStrobe = 1'b0;
        serialDataIn = ~serialDataIn; // Released line must not keep the last bit
    endtask
endmodule // fc_controller_model
`default_nettype wire

// file: tb/tb_led_driver_fc_write_path.sv
// Self-checking bench for the function control write path
`timescale 1ns/1ns
`default_nettype none
module tb_led_driver_fc_write_path;
    import led_fc_pkg::*;

    // Reserved primary bits 7:5 and 12:10, always sent as zero
    localparam logic [43:0] RSV_MASK = 44'h000_0000_1ce0;
    localparam logic [43:0] PRIM_DEF = {3'h4, 9'h100, 9'h100, 9'h100, 9'h000, 1'h1, 2'h1, 2'h1};

    logic core_clk = 1'b0;
    logic reset = 1'b1;
    wire logic shiftClk;
    wire logic serialDataIn;
    wire logic latchStrobe;
    logic serialDataOut_r;
    logic [43:0] functionControlPrimary_r;
    logic [16:0] functionControlSecondary_r;
    logic controlWriteUnlock_r;
    logic dataWriteRejected_r;
    logic grayscaleLatch_r;
    logic [47:0] grayscaleData_r;
    logic [7:0] lastEdgeCount_r;
    logic [1:0] openDetectThreshold_r;
    logic [1:0] outputHoldSelect_r;
    logic ghostCancelEnable_r;
    logic prechargeOn_r;
    logic prechargeAltMode_r;
    logic centerUniformityOn_r;
    logic [8:0] blueLevel_r;
    logic [8:0] greenLevel_r;
    logic [8:0] redLevel_r;
    logic [2:0] globalBrightness_r;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int rejectPulses = 0;
    int gsPulses = 0;

    led_driver_fc_write_path #(.GS_LATCH_EDGES(8'h01)) u_led_driver_fc_write_path (
        .core_clk(core_clk), .reset(reset), .shiftClk(shiftClk), .serialDataIn(serialDataIn),
        .latchStrobe(latchStrobe), .serialDataOut_r(serialDataOut_r),
        .functionControlPrimary_r(functionControlPrimary_r),
        .functionControlSecondary_r(functionControlSecondary_r),
        .controlWriteUnlock_r(controlWriteUnlock_r), .dataWriteRejected_r(dataWriteRejected_r),
        .grayscaleLatch_r(grayscaleLatch_r), .grayscaleData_r(grayscaleData_r),
        .lastEdgeCount_r(lastEdgeCount_r), .openDetectThreshold_r(openDetectThreshold_r),
        .outputHoldSelect_r(outputHoldSelect_r), .ghostCancelEnable_r(ghostCancelEnable_r),
        .prechargeOn_r(prechargeOn_r), .prechargeAltMode_r(prechargeAltMode_r),
        .centerUniformityOn_r(centerUniformityOn_r), .blueLevel_r(blueLevel_r),
        .greenLevel_r(greenLevel_r), .redLevel_r(redLevel_r), .globalBrightness_r(globalBrightness_r)
    );

    fc_controller_model u_fc_controller_model (
        .shiftClk(shiftClk), .serialDataIn(serialDataIn), .latchStrobe(latchStrobe)
    );

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // Pulse counters and hang guard; a run needs under two thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (dataWriteRejected_r === 1'b1) rejectPulses <= rejectPulses + 1;
        if (grayscaleLatch_r === 1'b1) gsPulses <= gsPulses + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    task automatic check_word(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Registers and every decoded field against the values they should hold
    task automatic check_regs(input logic [43:0] p, input logic [16:0] s);
        logic [37:0] got;
        logic [37:0] exp;
        got = {openDetectThreshold_r, outputHoldSelect_r, ghostCancelEnable_r, prechargeOn_r,
               prechargeAltMode_r, centerUniformityOn_r, blueLevel_r, greenLevel_r, redLevel_r,
               globalBrightness_r};
        exp = {p[1:0], p[3:2], p[4], ~p[8], p[9] & s[7], ~p[13], p[22:14], p[31:23], p[40:32], p[43:41]};
        check_word(48'(functionControlPrimary_r), 48'(p));
        check_word(48'(functionControlSecondary_r), 48'(s));
        check_word(48'(got), 48'(exp));
    endtask

    // Decode lands within three core cycles of the strobe fall
    task automatic command(input logic [47:0] word, input int nEdges);
        u_fc_controller_model.send_frame(word, nEdges);
        repeat (12) @(posedge core_clk);
    endtask

    // Every data write is preceded by its own unlock; only the primary has reserved bits to clear
    task automatic write_fc(input logic [3:0] sel, input logic [43:0] data);
        command(48'h0000_0000_0000, 15);
        command({sel, ((sel == SEL_PRIMARY) ? (data & ~RSV_MASK) : data)}, 5);
    endtask

    task automatic test_reset();
        check_regs(PRIM_DEF, 17'h0_0000);
        check_word(48'(controlWriteUnlock_r), 48'h0000_0000_0000);
        $display("test reset done");
    endtask

    task automatic test_locked_write();
        int nBefore;
        nBefore = rejectPulses;
        command({4'h9, 44'h000_0000_0000}, 5);
        check_count(rejectPulses, nBefore + 1);
        check_regs(PRIM_DEF, 17'h0_0000);
        $display("test locked write done");
    endtask

    // All four threshold codes, boundary levels; all-ones last leaves bit 9 set
    task automatic test_primary_writes();
        logic [43:0] vals [4];
        logic [43:0] v;
        vals = '{44'h000_0000_0000, 44'h5a5_a5a5_a5a6, 44'h2b3_c4d5_e6f5, 44'hfff_ffff_ffff};
        for (int i = 0; i < 4; i++) begin
            v = vals[i] & ~RSV_MASK;
            write_fc(4'h9, v);
            check_regs(v, 17'h0_0000);
            check_word(48'(lastEdgeCount_r), 48'h0000_0000_0005);
            check_word(48'(controlWriteUnlock_r), 48'h0000_0000_0000);
        end
        $display("test primary writes done");
    endtask

    task automatic test_secondary_write();
        logic [43:0] p;
        p = 44'hfff_ffff_ffff & ~RSV_MASK;
        write_fc(4'h6, 44'habc_def1_2385);
        check_regs(p, 17'h1_2385);
        $display("test secondary write done");
    endtask

    task automatic test_unlock_rules();
        logic [43:0] p;
        int nBefore;
        p = 44'hfff_ffff_ffff & ~RSV_MASK;
        command(48'h0000_0000_0000, 15);
        check_word(48'(controlWriteUnlock_r), 48'h0000_0000_0001);
        check_word(48'(lastEdgeCount_r), 48'h0000_0000_000f);
        command(48'h0000_0000_0000, 3);
        check_word(48'(controlWriteUnlock_r), 48'h0000_0000_0000);
        nBefore = rejectPulses;
        command({4'h9, 44'h000_0000_0000}, 5);
        check_count(rejectPulses, nBefore + 1);
        write_fc(4'h3, 44'h000_0000_0000);
        check_regs(p, 17'h1_2385);
        command({4'h9, 44'h000_0000_0000}, 5);
        check_count(rejectPulses, nBefore + 2);
        check_regs(p, 17'h1_2385);
        $display("test unlock rules done");
    endtask

    // One edge under strobe latches grayscale; then the word walks out serially
    task automatic test_grayscale_shift();
        logic [47:0] w;
        int nBefore;
        w = 48'h9c3a_5f01_e7d2;
        nBefore = gsPulses;
        command(w, 1);
        check_count(gsPulses, nBefore + 1);
        check_word(grayscaleData_r, w);
        check_word(48'(serialDataOut_r), 48'(w[47]));
        for (int k = 1; k < 48; k++) begin
            u_fc_controller_model.idle_clocks(1);
            check_word(48'(serialDataOut_r), 48'(w[47 - k]));
        end
        $display("test grayscale and shift done");
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Shift clock must run past the release so the link side leaves reset before the first frame
    initial begin
        fork
            u_fc_controller_model.idle_clocks(8);
        join_none
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (6) @(posedge core_clk);
        test_reset();
        test_locked_write();
        test_primary_writes();
        test_secondary_write();
        test_unlock_rules();
        test_grayscale_shift();
        end_of_test();
    end
endmodule // tb_led_driver_fc_write_path
`default_nettype wire
